// file: logic/spd_regs.sv
`timescale 1ns/1ps
`include "spd_defines.svh"

module spd_regs #(
   parameter int unsigned WIN_CYCLES  = `SPD_WIN_CYCLES,
   parameter int unsigned WDOG_CYCLES = `SPD_WDOG_CYCLES
) (
   // Clock and reset.
   input  wire logic                     clk,
   input  wire logic                     reset,
   // APB slave.
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [`SPD_ADDR_W-1:0]   paddr,
   input  wire logic [31:0]              pwdata,
   output      logic [31:0]              prdata,
   output      logic                     pready,
   output      logic                     pslverr,
   // Sensor front end.
   input  wire logic                     sensorPulse,
   input  wire logic                     openWireSense,
   // Speed outputs.
   output      logic [15:0]              speed16,
   output      logic                     speed16Valid,
   output      logic [31:0]              speed32,
   output      logic                     speed32Valid,
   // Relay drive.
   output      logic                     relayEnergized,
   // Indicators.
   output      logic                     ledComm,
   output      logic                     ledInternalErr,
   output      logic                     ledExternalErr,
   output      logic                     ledOverspeed,
   output      logic                     ledRelay
);

   localparam logic [`SPD_WIN_W-1:0]  WIN_LAST  =
      `SPD_WIN_W'(WIN_CYCLES - 1);
   localparam logic [`SPD_WDOG_W-1:0] WDOG_LAST =
      `SPD_WDOG_W'(WDOG_CYCLES - 1);
   localparam logic [23:0]            HZ_SCALE  = 24'(`SPD_HZ_SCALE);

   spd_pkg::spd_state_t s;
   spd_pkg::spd_state_t next_s;

   logic [5:0]  regIdx;
   logic        addrHit;
   logic        cfgHit;
   logic        apbStart;
   logic        apbDone;
   logic        readClr;
   logic        rise;
   logic [15:0] winNow;
   logic [23:0] scaled;
   logic [15:0] perNext;
   logic [15:0] statusWord;
   logic [31:0] readData;

   assign regIdx   = paddr[7:2];
   assign cfgHit   = (paddr[1:0] == 2'b00) && (regIdx == `SPD_IDX_CFG);
   assign addrHit  = (paddr[1:0] == 2'b00) &&
                     ((regIdx == `SPD_IDX_THRESH) ||
                      (regIdx == `SPD_IDX_CFG) ||
                      (regIdx == `SPD_IDX_PULSES));
   assign apbStart = psel && penable && !s.pready;
   assign apbDone  = psel && penable && s.pready;
   assign readClr  = apbDone && !pwrite && cfgHit &&
                     s.prdata[`SPD_BIT_OVER_SEEN];
   assign rise     = sensorPulse && !s.prevPulse;
   assign perNext  = s.perPulses + 16'h0001;

   // Status word, assembled live from the block's own state.
   always_comb begin
      statusWord                     = 16'h0000;
      statusWord[`SPD_BIT_CONF]      = s.configured;
      statusWord[`SPD_BIT_FORCE]     = s.forceErr;
      statusWord[`SPD_BIT_OW_DET]    = s.owDet;
      statusWord[`SPD_BIT_OW_EN]     = s.owTestEn;
      statusWord[`SPD_BIT_OVER_NOW]  = s.curOver;
      statusWord[`SPD_BIT_OVER_SEEN] = s.stickyOver;
      statusWord[`SPD_BIT_RELAY]     = s.relay;
      statusWord[`SPD_BIT_RCTL0]     = s.relayCtl[0];
      statusWord[`SPD_BIT_RCTL1]     = s.relayCtl[1];
   end

   always_comb begin
      readData = 32'h0000_0000;
      if (addrHit) begin
         unique case (regIdx)
            `SPD_IDX_THRESH: readData = {16'h0000, s.threshold};
            `SPD_IDX_CFG:    readData = {16'h0000, statusWord};
            `SPD_IDX_PULSES: readData = {16'h0000, s.pulsesPerUpdate};
            default:         readData = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      next_s              = s;
      next_s.speed16Valid = 1'b0;
      next_s.speed32Valid = 1'b0;
      next_s.prevPulse    = sensorPulse;
      winNow              = s.winPulses;
      scaled              = 24'h00_0000;

      // APB: one wait state, answer registered in the first access cycle.
      if (apbStart) begin
         next_s.pready  = 1'b1;
         next_s.pslverr = !addrHit;
         next_s.prdata  = (!pwrite && addrHit) ? readData : 32'h0000_0000;
      end else if (apbDone) begin
         next_s.pready  = 1'b0;
         next_s.pslverr = 1'b0;
      end

      if (apbDone && pwrite && addrHit) begin
         unique case (regIdx)
            `SPD_IDX_THRESH: begin
               next_s.threshold = pwdata[15:0];
            end
            `SPD_IDX_CFG: begin
               next_s.configured  = pwdata[`SPD_BIT_CONF];
               next_s.forceErr    = pwdata[`SPD_BIT_FORCE];
               next_s.owTestEn    = pwdata[`SPD_BIT_OW_EN];
               next_s.relayCtl[0] = pwdata[`SPD_BIT_RCTL0];
               next_s.relayCtl[1] = pwdata[`SPD_BIT_RCTL1];
            end
            `SPD_IDX_PULSES: begin
               next_s.pulsesPerUpdate = pwdata[15:0];
            end
            default: begin
               next_s.threshold = s.threshold;
            end
         endcase
      end

      // Measurement is stopped and cleared while unconfigured.
      if (!s.configured) begin
         next_s.winCnt    = '0;
         next_s.winPulses = 16'h0000;
         next_s.perArmed  = 1'b0;
         next_s.perCnt    = 32'h0000_0000;
         next_s.perPulses = 16'h0000;
         next_s.curOver   = 1'b0;
      end else begin
         if (rise && (s.winPulses != 16'hFFFF)) begin
            winNow = s.winPulses + 16'h0001;
         end
         // Fixed-window 16-bit speed in hertz.
         if (s.winCnt == WIN_LAST) begin
            scaled              = 24'(winNow) * HZ_SCALE;
            next_s.winCnt       = '0;
            next_s.winPulses    = 16'h0000;
            next_s.speed16      = (scaled[23:16] != 8'h00) ?
                                  16'hFFFF : scaled[15:0];
            next_s.speed16Valid = 1'b1;
            next_s.curOver      = (next_s.speed16 > s.threshold);
         end else begin
            next_s.winCnt    = s.winCnt + `SPD_WIN_W'(1);
            next_s.winPulses = winNow;
         end
         // Period of the programmed number of pulses, in clock cycles.
         if (s.perCnt != 32'hFFFF_FFFF) begin
            next_s.perCnt = s.perCnt + 32'h0000_0001;
         end
         if (rise) begin
            if (!s.perArmed) begin
               next_s.perArmed  = 1'b1;
               next_s.perCnt    = 32'h0000_0000;
               next_s.perPulses = 16'h0000;
            end else if ((s.pulsesPerUpdate != 16'h0000) &&
                         (perNext == s.pulsesPerUpdate)) begin
               next_s.speed32      = next_s.perCnt;
               next_s.speed32Valid = 1'b1;
               next_s.perCnt       = 32'h0000_0000;
               next_s.perPulses    = 16'h0000;
            end else begin
               next_s.perPulses = perNext;
            end
         end
      end

      // Latched overspeed: a new event wins over the read clear.
      next_s.stickyOver = (s.stickyOver && !readClr) ||
                          next_s.curOver;

      next_s.owDet = s.owTestEn && openWireSense;
      next_s.relay = s.configured &&
                     ((s.relayCtl[0] && next_s.curOver) ||
                      s.relayCtl[1]);

      // Communication watchdog, restarted by every completed access.
      if (apbDone) begin
         next_s.wdogCnt     = '0;
         next_s.wdogExpired = 1'b0;
      end else if (!s.wdogExpired) begin
         if (s.wdogCnt == WDOG_LAST) begin
            next_s.wdogExpired = 1'b1;
         end else begin
            next_s.wdogCnt = s.wdogCnt + `SPD_WDOG_W'(1);
         end
      end

      next_s.ledComm        = !next_s.wdogExpired;
      next_s.ledInternalErr = next_s.forceErr || next_s.wdogExpired;
      next_s.ledExternalErr = next_s.owDet;
      next_s.ledOverspeed   = next_s.curOver;
      next_s.ledRelay       = next_s.relay;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         s                 <= '0;
         s.threshold       <= `SPD_RST_THRESH;
         s.pulsesPerUpdate <= `SPD_RST_PULSES;
         s.wdogExpired     <= 1'b1;
         s.ledInternalErr  <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign prdata         = s.prdata;
   assign pready         = s.pready;
   assign pslverr        = s.pslverr;
   assign speed16        = s.speed16;
   assign speed16Valid   = s.speed16Valid;
   assign speed32        = s.speed32;
   assign speed32Valid   = s.speed32Valid;
   assign relayEnergized = s.relay;
   assign ledComm        = s.ledComm;
   assign ledInternalErr = s.ledInternalErr;
   assign ledExternalErr = s.ledExternalErr;
   assign ledOverspeed   = s.ledOverspeed;
   assign ledRelay       = s.ledRelay;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   property p_cfg_write;
      apbDone && pwrite && cfgHit |=>
         (s.configured == $past(pwdata[`SPD_BIT_CONF])) &&
         (s.owTestEn == $past(pwdata[`SPD_BIT_OW_EN]));
   endproperty
   a_cfg_write: assert property (p_cfg_write)
      else $error("Configuration write not loaded.");

   property p_status_read;
      apbStart && !pwrite && cfgHit |=>
         pready && (prdata[`SPD_BIT_CONF] == $past(s.configured)) &&
         (prdata[`SPD_BIT_FORCE] == $past(s.forceErr)) &&
         (prdata[31:16] == 16'h0000);
   endproperty
   a_status_read: assert property (p_status_read)
      else $error("Status word read back wrong.");

   property p_halt;
      !s.configured |=> !speed16Valid && !speed32Valid && !s.curOver;
   endproperty
   a_halt: assert property (p_halt)
      else $error("Speed output while unconfigured.");

   property p_force_led;
      s.forceErr |-> ledInternalErr;
   endproperty
   a_force_led: assert property (p_force_led)
      else $error("Internal error indicator off with forced error.");

   property p_comm_led;
      apbDone |=> ledComm && !s.wdogExpired ##1 ledComm;
   endproperty
   a_comm_led: assert property (p_comm_led)
      else $error("Communications indicator off after access.");

   property p_sticky_hold;
      s.curOver |-> s.stickyOver && ledOverspeed;
   endproperty
   a_sticky_hold: assert property (p_sticky_hold)
      else $error("Overspeed not latched with current flag.");

   property p_sticky_clear;
      readClr |=> (s.stickyOver == s.curOver);
   endproperty
   a_sticky_clear: assert property (p_sticky_clear)
      else $error("Latched overspeed not cleared by read.");

   property p_win;
      speed16Valid |-> $past(s.winCnt) == WIN_LAST && s.winCnt == '0;
   endproperty
   a_win: assert property (p_win)
      else $error("16-bit speed update off its window.");

   property p_upd32;
      speed32Valid |-> $past(rise) &&
         ($past(s.perPulses) + 16'h0001 == $past(s.pulsesPerUpdate));
   endproperty
   a_upd32: assert property (p_upd32)
      else $error("32-bit speed update at wrong pulse count.");

   property p_ext_led;
      s.owDet |-> ledExternalErr && $past(s.owTestEn);
   endproperty
   a_ext_led: assert property (p_ext_led)
      else $error("External error indicator does not follow open wire.");

   property p_relay_led;
      s.configured && s.relayCtl[1] |=> relayEnergized && ledRelay;
   endproperty
   a_relay_led: assert property (p_relay_led)
      else $error("Relay indicator differs from relay state.");

   property p_unmapped;
      apbStart && !addrHit |=> pready && pslverr && prdata == '0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("Unmapped access not refused.");

   property p_force_write;
      apbDone && pwrite && cfgHit |=>
         (s.forceErr == $past(pwdata[`SPD_BIT_FORCE]));
   endproperty
   a_force_write: assert property (p_force_write)
      else $error("Forced error bit not loaded.");

   property p_thresh_write;
      apbDone && pwrite && (paddr == `SPD_ADDR_THRESH) |=>
         (s.threshold == $past(pwdata[15:0]));
   endproperty
   a_thresh_write: assert property (p_thresh_write)
      else $error("Overspeed setting not loaded.");

   property p_ow_det;
      s.owTestEn && openWireSense |=> s.owDet && ledExternalErr;
   endproperty
   a_ow_det: assert property (p_ow_det)
      else $error("Open wire not flagged.");

   property p_over_set;
      speed16Valid |-> (s.curOver == (speed16 > $past(s.threshold)));
   endproperty
   a_over_set: assert property (p_over_set)
      else $error("Overspeed flag disagrees with speed and setting.");

   property p_wdog_expire;
      (s.wdogCnt == WDOG_LAST) && !s.wdogExpired && !apbDone |=>
         !ledComm && ledInternalErr;
   endproperty
   a_wdog_expire: assert property (p_wdog_expire)
      else $error("Watchdog expiry not shown on indicators.");

   c_sticky_clear: cover property (readClr ##1 !s.stickyOver);
   c_upd32: cover property (speed32Valid);
   c_over: cover property (s.configured && speed16Valid && s.curOver);
   c_refused: cover property (apbDone && s.pslverr);

endmodule

// file: logic/spd_defines.svh
`ifndef SPD_DEFINES_SVH
`define SPD_DEFINES_SVH

// Register indices and their APB byte addresses (four times the index).
`define SPD_IDX_THRESH      6'd12
`define SPD_IDX_CFG         6'd13
`define SPD_IDX_PULSES      6'd14
`define SPD_ADDR_W          8
`define SPD_ADDR_THRESH     8'h30
`define SPD_ADDR_CFG        8'h34
`define SPD_ADDR_PULSES     8'h38

// Configuration and status bit positions.
`define SPD_BIT_CONF        0
`define SPD_BIT_FORCE       1
`define SPD_BIT_OW_DET      4
`define SPD_BIT_OW_EN       5
`define SPD_BIT_OVER_NOW    10
`define SPD_BIT_OVER_SEEN   11
`define SPD_BIT_RELAY       12
`define SPD_BIT_RCTL0       14
`define SPD_BIT_RCTL1       15

// Reset values.
`define SPD_RST_THRESH      16'h0000
`define SPD_RST_PULSES      16'h0000

// Timing.
`define SPD_CLK_HZ          25000000
`define SPD_WIN_MS          5
`define SPD_WDOG_S          2
`define SPD_WIN_CYCLES      ((`SPD_CLK_HZ / 1000) * `SPD_WIN_MS)
`define SPD_WDOG_CYCLES     (`SPD_CLK_HZ * `SPD_WDOG_S)
`define SPD_HZ_SCALE        (1000 / `SPD_WIN_MS)
`define SPD_WIN_W           17
`define SPD_WDOG_W          26

`endif

// file: logic/spd_pkg.sv
`include "spd_defines.svh"

package spd_pkg;

   typedef struct packed {
      logic                     configured;
      logic                     forceErr;
      logic                     owTestEn;
      logic [1:0]               relayCtl;
      logic [15:0]              threshold;
      logic [15:0]              pulsesPerUpdate;
      logic                     prevPulse;
      logic [`SPD_WIN_W-1:0]    winCnt;
      logic [15:0]              winPulses;
      logic [15:0]              speed16;
      logic                     speed16Valid;
      logic                     perArmed;
      logic [31:0]              perCnt;
      logic [15:0]              perPulses;
      logic [31:0]              speed32;
      logic                     speed32Valid;
      logic                     curOver;
      logic                     stickyOver;
      logic                     owDet;
      logic                     relay;
      logic [`SPD_WDOG_W-1:0]   wdogCnt;
      logic                     wdogExpired;
      logic                     pready;
      logic                     pslverr;
      logic [31:0]              prdata;
      logic                     ledComm;
      logic                     ledInternalErr;
      logic                     ledExternalErr;
      logic                     ledOverspeed;
      logic                     ledRelay;
   } spd_state_t;

endpackage

// file: dv/spd_sensor_model.sv
`timescale 1ns/1ps

module spd_sensor_model (
   // Clock.
   input  wire logic        clk,
   // Control from the bench.
   input  wire logic        enable,
   input  wire logic [15:0] period,
   input  wire logic        openWire,
   // Sensor front end outputs.
   output      logic        sensorPulse,
   output      logic        openWireSense
);
   logic [15:0] phase;

   initial begin
      phase = 16'h0000;
      sensorPulse = 1'b0;
      openWireSense = 1'b0;
   end

   // Square wave, high for half the period, so a low sample always separates
   // two rises; the wire stays low while the sensor is stopped.
   always @(posedge clk) begin
      if (!enable) begin
         phase <= 16'h0000;
         sensorPulse <= 1'b0;
      end else begin
         phase <= (phase + 16'h0001 >= period) ? 16'h0000 : phase + 16'h0001;
         sensorPulse <= (phase < (period >> 1));
      end
      openWireSense <= openWire;
   end
endmodule

// file: dv/spd_testbench.sv
`timescale 1ns/1ps
`include "spd_defines.svh"

module testbench;
   localparam int WIN  = 50;
   localparam int WDOG = 400;

   // Bench state.
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        sensEn = 1'b0;
   logic        owReq = 1'b0;
   logic [15:0] period = 16'h000A;
   int          numErrors = 0;
   int          checked = 0;
   int          cycles = 0;
   int          n;
   // Design and sensor model outputs.
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sensorPulse;
   logic        openWireSense;
   logic [15:0] speed16;
   logic        speed16Valid;
   logic [31:0] speed32;
   logic        speed32Valid;
   logic        relayEnergized;
   logic        ledComm;
   logic        ledInternalErr;
   logic        ledExternalErr;
   logic        ledOverspeed;
   logic        ledRelay;

   always #20 clk = ~clk;

   spd_regs #(.WIN_CYCLES(WIN), .WDOG_CYCLES(WDOG)) dut_u (
      .clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sensorPulse(sensorPulse),
      .openWireSense(openWireSense), .speed16(speed16),
      .speed16Valid(speed16Valid), .speed32(speed32),
      .speed32Valid(speed32Valid), .relayEnergized(relayEnergized),
      .ledComm(ledComm), .ledInternalErr(ledInternalErr),
      .ledExternalErr(ledExternalErr), .ledOverspeed(ledOverspeed),
      .ledRelay(ledRelay)
   );

   spd_sensor_model sensor_u (
      .clk(clk), .enable(sensEn), .period(period), .openWire(owReq),
      .sensorPulse(sensorPulse), .openWireSense(openWireSense)
   );

   task automatic testDone();
      $display("Comparisons %0d, mismatches %0d", checked, numErrors);
      if (numErrors == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string msg);
      checked++;
      if (seen !== exp) begin
         numErrors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h",
                  $time, msg, seen, exp);
      end
   endtask

   // One APB transfer; the request is held until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
      int k;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      chk({31'h0, k < 50}, 32'h0000_0001, "bus answer");
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, a, d, rd, err);
      chk({31'h0, err}, 32'h0000_0000, "write error");
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
                        input logic errExp);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, a, 32'h0000_0000, rd, err);
      chk(rd, exp, "read data");
      chk({31'h0, err}, {31'h0, errExp}, "read error flag");
   endtask

   task automatic waitValid(input logic is32);
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while ((is32 ? speed32Valid : speed16Valid) !== 1'b1 && k < 500);
      chk({31'h0, k < 500}, 32'h0000_0001, "speed update");
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         numErrors++;
         $display("CHECK FAILED at %0t: run timed out", $time);
         testDone();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk({31'h0, ledInternalErr}, 32'h0000_0001, "err led at reset");
      chk({31'h0, ledComm}, 32'h0000_0000, "comm led at reset");
      rdchk(`SPD_ADDR_THRESH, 32'h0000_0000, 1'b0);
      rdchk(`SPD_ADDR_PULSES, 32'h0000_0000, 1'b0);
      rdchk(`SPD_ADDR_CFG, 32'h0000_0000, 1'b0);
      chk({31'h0, ledComm}, 32'h0000_0001, "comm led lit");
      chk({31'h0, ledInternalErr}, 32'h0000_0000, "err led off");
      wr(`SPD_ADDR_THRESH, 32'hABCD_1234);
      rdchk(`SPD_ADDR_THRESH, 32'h0000_1234, 1'b0);
      rdchk(8'h3C, 32'h0000_0000, 1'b1);
      rdchk(8'h31, 32'h0000_0000, 1'b1);
      $display("Test registers done");

      wr(`SPD_ADDR_CFG, 32'h0000_3FFF);
      rdchk(`SPD_ADDR_CFG, 32'h0000_0023, 1'b0);
      chk({31'h0, ledInternalErr}, 32'h0000_0001, "forced err led");
      owReq <= 1'b1;
      repeat (4) @(negedge clk);
      chk({31'h0, ledExternalErr}, 32'h0000_0001, "open wire led");
      rdchk(`SPD_ADDR_CFG, 32'h0000_0033, 1'b0);
      owReq <= 1'b0;
      wr(`SPD_ADDR_CFG, 32'h0000_8001);
      rdchk(`SPD_ADDR_CFG, 32'h0000_9001, 1'b0);
      chk({30'h0, relayEnergized, ledRelay}, 32'h0000_0003, "relay");
      chk({30'h0, ledInternalErr, ledExternalErr}, 32'h0, "leds off");
      $display("Test config and status done");

      // Gear of three teeth: three pulses per update is one revolution.
      wr(`SPD_ADDR_PULSES, 32'h0000_0003);
      rdchk(`SPD_ADDR_PULSES, 32'h0000_0003, 1'b0);
      wr(`SPD_ADDR_THRESH, 32'h0000_03E8);
      sensEn <= 1'b1;
      wr(`SPD_ADDR_CFG, 32'h0000_4001);
      waitValid(1'b0);
      waitValid(1'b0);
      chk({16'h0, speed16}, 32'h0000_03E8, "speed16");
      rdchk(`SPD_ADDR_CFG, 32'h0000_4001, 1'b0);
      waitValid(1'b1);
      waitValid(1'b1);
      chk(speed32, 32'h0000_001E, "speed32");
      $display("Test speed done");

      wr(`SPD_ADDR_THRESH, 32'h0000_03E7);
      waitValid(1'b0);
      waitValid(1'b0);
      @(negedge clk);
      chk({31'h0, ledOverspeed}, 32'h0000_0001, "overspeed led");
      chk({31'h0, relayEnergized}, 32'h0000_0001, "relay on over");
      rdchk(`SPD_ADDR_CFG, 32'h0000_5C01, 1'b0);
      rdchk(`SPD_ADDR_CFG, 32'h0000_5C01, 1'b0);
      wr(`SPD_ADDR_THRESH, 32'h0000_FFFF);
      waitValid(1'b0);
      waitValid(1'b0);
      @(negedge clk);
      rdchk(`SPD_ADDR_CFG, 32'h0000_4801, 1'b0);
      rdchk(`SPD_ADDR_CFG, 32'h0000_4001, 1'b0);
      chk({31'h0, ledOverspeed}, 32'h0000_0000, "overspeed led off");
      $display("Test overspeed done");

      wr(`SPD_ADDR_CFG, 32'h0000_0000);
      @(posedge clk);
      n = 0;
      repeat (3 * WIN) begin
         @(negedge clk);
         if (speed16Valid !== 1'b0 || speed32Valid !== 1'b0) n++;
      end
      chk(n, 32'h0000_0000, "updates while halted");
      rdchk(`SPD_ADDR_CFG, 32'h0000_0000, 1'b0);
      $display("Test unconfigure done");

      repeat (WDOG - 20) @(negedge clk);
      chk({31'h0, ledComm}, 32'h0000_0001, "comm led held");
      repeat (40) @(negedge clk);
      chk({30'h0, ledComm, ledInternalErr}, 32'h1, "watchdog expiry");
      rdchk(`SPD_ADDR_CFG, 32'h0000_0000, 1'b0);
      @(negedge clk);
      chk({31'h0, ledComm}, 32'h0000_0001, "comm led back");
      $display("Test watchdog done");
      testDone();
   end
endmodule
